/* File: rtl/pms_top.sv */
// Purpose: microphone inputs on shared pins and the shared pin mode logic
// Assumes: fs_tick marks each audio sample; mic_bclk is the master bit clock
// Notes: registers are 16 bits wide on the slave control port
// How it works
// [RULE1] at most four microphone channels, fixed numbers
// [RULE2] one shared pin carries one microphone pair
// [RULE3] two control registers select the data pins
// [RULE4] first register gives channels 0,1; second 2,3
// [RULE5] master bit clock drives the microphones
// [RULE6] host runs that port two-channel, 16-48 kHz
// [RULE7] bitstreams decimated automatically, samples offered out
// [RULE8] twenty-five shared general-purpose pins
// [RULE9] per-pin mode register selects seven modes
// [RULE10] hardware input mode has optional debounce
// [RULE11] general-purpose pin state refreshed once per sample
// [RULE12] input valid only in input modes; outputs likewise
// [RULE13] left on rising edge, right on falling
`timescale 1ns/1ns
`include "pms_regs.svh"
module pms_top #(
	parameter int NPINS   = 25,
	parameter int DEB_CYC = `PMS_DEB_CYC,
	parameter int DECIM   = `PMS_DECIM
) (
	input  wire logic          clk,         // core clock, 100 MHz
	input  wire logic          reset,       // async reset, active high
	input  wire logic          mic_bclk,    // master bit clock sent to microphones
	input  pms_pkg::pms_reg_req_t reg_req,  // control port register request
	output logic [15:0]        reg_rdata,   // read data, one cycle after rd
	input  wire logic          fs_tick,     // one pulse per audio sample
	input  wire logic [24:0]   pin_in,      // shared pin input levels
	output logic [24:0]        pin_out,     // shared pin output levels
	output logic [24:0]        pin_oe,      // high while pin is driven
	output logic [24:0]        pin_pu,      // internal pull-up enable
	input  wire logic [24:0]   gp_from_core, // program values for output pins
	output logic [24:0]        gp_to_core,  // pin values seen by the program
	output logic [24:0]        gp_in_valid, // value valid, pin set as input
	input  wire logic          fault_flag,  // flag from the fault manager
	input  wire logic          spi_ss,      // select line of the master serial port
	output pms_pkg::pms_pair_t mic_pair0,   // channels 0 and 1
	output pms_pkg::pms_pair_t mic_pair1,   // channels 2 and 3
	output logic [3:0]         mic_valid,   // one-cycle pulse per channel sample
	output logic               mic_clk_req  // ask for the bit clock as master
);
	import pms_pkg::*;
	pms_mic_ctrl_t mic_ctrl_r [2];
	pms_mic_ctrl_t mic_ctrl_nxt [2];
	pms_pin_cfg_t  cfg_r [NPINS];
	pms_pin_cfg_t  cfg_nxt [NPINS];
	logic [NPINS-1:0] sw_r, sw_nxt, deb_q, in_mask, out_mask;
	logic [NPINS-1:0] gout_r, gout_nxt, gin_r, gin_nxt, vld_r;
	logic [NPINS-1:0] po_nxt, oe_nxt, pu_nxt, po_r, oe_r, pu_r;
	logic          fault_r, ss_r;
	logic [15:0]   rdata_r, rdata_nxt;
	logic [5:0]    hit_mode, hit_wr, hit_rd;
	logic [1:0]    pair_en, pair_vld;
	logic [1:0]    pair_data;
	pms_pair_t     pair_smp [2];

	// decode an address against the two banks of per-pin registers
	function automatic logic [5:0] pin_dec(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] d;
		d = 16'h0000;
		pin_dec = 6'h00;
		if (a >= lo && a < lo + `PMS_LO_PINS) begin
			d = a - lo;
			pin_dec = {1'b1, d[4:0]};
		end else if (a >= hi && a < hi + `PMS_HI_PINS) begin
			d = a - hi + `PMS_LO_PINS;
			pin_dec = {1'b1, d[4:0]};
		end
	endfunction

	assign hit_mode = pin_dec(reg_req.addr, `PMS_MODE_LO, `PMS_MODE_HI);
	assign hit_wr = pin_dec(reg_req.addr, `PMS_WR_LO, `PMS_WR_HI);
	assign hit_rd = pin_dec(reg_req.addr, `PMS_RD_LO, `PMS_RD_HI);

	// register writes and read data
	always_comb begin
		mic_ctrl_nxt = mic_ctrl_r;
		cfg_nxt = cfg_r;
		sw_nxt = sw_r;
		rdata_nxt = rdata_r;
		if (reg_req.wr) begin
			if (reg_req.addr == `PMS_MIC_CTRL0) begin
				mic_ctrl_nxt[0] = reg_req.wdata; // [RULE3]
			end else if (reg_req.addr == `PMS_MIC_CTRL1) begin
				mic_ctrl_nxt[1] = reg_req.wdata; // [RULE3]
			end else if (hit_mode[5]) begin
				cfg_nxt[hit_mode[4:0]] = reg_req.wdata[3:0]; // [RULE9]
			end else if (hit_wr[5]) begin
				sw_nxt[hit_wr[4:0]] = reg_req.wdata[0];
			end
		end
		if (reg_req.rd) begin
			if (reg_req.addr == `PMS_MIC_CTRL0) begin
				rdata_nxt = mic_ctrl_r[0];
			end else if (reg_req.addr == `PMS_MIC_CTRL1) begin
				rdata_nxt = mic_ctrl_r[1];
			end else if (hit_mode[5]) begin
				rdata_nxt = {12'h000, cfg_r[hit_mode[4:0]]};
			end else if (hit_wr[5]) begin
				rdata_nxt = {15'h0000, sw_r[hit_wr[4:0]]};
			end else if (hit_rd[5]) begin
				rdata_nxt = {15'h0000, gin_r[hit_rd[4:0]]};
			end else begin
				rdata_nxt = 16'h0000;
			end
		end
	end

	// register file
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mic_ctrl_r[0] <= `PMS_MIC_CTRL_RST;
			mic_ctrl_r[1] <= `PMS_MIC_CTRL_RST;
			for (int i = 0; i < NPINS; i++) begin
				cfg_r[i] <= `PMS_MODE_RST;
			end
			sw_r <= '0;
			rdata_r <= 16'h0000;
		end else begin
			mic_ctrl_r <= mic_ctrl_nxt;
			cfg_r <= cfg_nxt;
			sw_r <= sw_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	// per-pin input stage and mode masks
	generate
		for (genvar g = 0; g < NPINS; g++) begin : g_pin
			pms_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
				.clk     (clk),
				.reset   (reset),
				.pin_raw (pin_in[g]),
				.deb_en  (cfg_r[g].deb && cfg_r[g].mode == PMS_HW_IN), // [RULE10]
				.q       (deb_q[g])
			);
			assign in_mask[g] = cfg_r[g].mode == PMS_HW_IN || cfg_r[g].mode == PMS_SW_IN; // [RULE12]
			assign out_mask[g] = cfg_r[g].mode == PMS_OUT_PU || cfg_r[g].mode == PMS_OUT_NOPU; // [RULE12]
		end
	endgenerate

	// general-purpose state moves only on the sample tick
	always_comb begin
		gout_nxt = gout_r;
		gin_nxt = gin_r;
		if (fs_tick) begin // [RULE11]
			for (int i = 0; i < NPINS; i++) begin
				gout_nxt[i] = out_mask[i] & gp_from_core[i]; // [RULE12]
				if (cfg_r[i].mode == PMS_SW_IN) gin_nxt[i] = sw_r[i];
				else if (cfg_r[i].mode == PMS_HW_IN) gin_nxt[i] = deb_q[i];
				else gin_nxt[i] = 1'b0;
			end
		end
	end

	// pin drive by mode
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			po_nxt[i] = 1'b0;
			oe_nxt[i] = 1'b0;
			pu_nxt[i] = 1'b0;
			case (cfg_r[i].mode) // [RULE8] [RULE9]
				PMS_OUT_PU: begin
					po_nxt[i] = gout_r[i];
					oe_nxt[i] = 1'b1;
					pu_nxt[i] = 1'b1;
				end
				PMS_OUT_NOPU: begin
					po_nxt[i] = gout_r[i];
					oe_nxt[i] = 1'b1;
				end
				PMS_FAULT: begin
					po_nxt[i] = fault_r;
					oe_nxt[i] = 1'b1;
				end
				PMS_SPI_SS: begin
					po_nxt[i] = ss_r;
					oe_nxt[i] = 1'b1;
				end
				default: begin
					po_nxt[i] = 1'b0;
				end
			endcase
		end
	end

	// pin and core-facing registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gout_r <= '0;
			gin_r <= '0;
			vld_r <= '0;
			po_r <= '0;
			oe_r <= '0;
			pu_r <= '0;
			fault_r <= 1'b0;
			ss_r <= 1'b0;
		end else begin
			gout_r <= gout_nxt;
			gin_r <= gin_nxt;
			vld_r <= in_mask;
			po_r <= po_nxt;
			oe_r <= oe_nxt;
			pu_r <= pu_nxt;
			fault_r <= fault_flag;
			ss_r <= spi_ss;
		end
	end
	assign pin_out = po_r;
	assign pin_oe = oe_r;
	assign pin_pu = pu_r;
	assign gp_to_core = gin_r & vld_r; // [RULE12]
	assign gp_in_valid = vld_r;

	// microphone pairs, each on one selected shared pin
	generate
		for (genvar p = 0; p < 2; p++) begin : g_pair
			// a pin index past the last shared pin never enables the pair
			assign pair_en[p] = mic_ctrl_r[p].en && mic_ctrl_r[p].pin < 5'(NPINS) &&
				cfg_r[mic_ctrl_r[p].pin].mode == PMS_MIC; // [RULE2]
			assign pair_data[p] = pin_in[mic_ctrl_r[p].pin]; // [RULE2]
			pms_mic_pair #(.DECIM(DECIM)) u_pair (
				.clk       (clk),
				.reset     (reset),
				.bclk      (mic_bclk), // [RULE5]
				.pdm_in    (pair_data[p]),
				.en        (pair_en[p]),
				.smp       (pair_smp[p]),
				.smp_valid (pair_vld[p])
			);
		end
	endgenerate
	assign mic_pair0 = pair_smp[0];
	assign mic_pair1 = pair_smp[1];
	assign mic_valid = {pair_vld[1], pair_vld[1], pair_vld[0], pair_vld[0]}; // [RULE1] [RULE4]
	assign mic_clk_req = |pair_en; // [RULE5]

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_tick_only;
		!fs_tick |=> gout_r == $past(gout_r) && gin_r == $past(gin_r);
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("pin state moved between samples"); // [RULE11]
	property p_in_valid;
		gp_in_valid[0] |-> ($past(cfg_r[0].mode) == PMS_HW_IN || $past(cfg_r[0].mode) == PMS_SW_IN);
	endproperty
	a_in_valid: assert property (p_in_valid) else $error("input valid on non-input pin"); // [RULE12]
	property p_oe_mode;
		cfg_r[0].mode == PMS_HW_IN && fs_tick ##1 cfg_r[0].mode == PMS_HW_IN ##1 cfg_r[0].mode == PMS_HW_IN
			|-> !pin_oe[0] && !gout_r[0];
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("input pin driven"); // [RULE12]
	property p_pu;
		pin_pu[5] |-> $past(cfg_r[5].mode) == PMS_OUT_PU && pin_oe[5];
	endproperty
	a_pu: assert property (p_pu) else $error("pull-up outside pull-up mode"); // [RULE9]
	property p_ctrl_wr;
		reg_req.wr && reg_req.addr == `PMS_MIC_CTRL1 |=> mic_ctrl_r[1] == $past(reg_req.wdata);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("second control register not written"); // [RULE3]
	property p_rd;
		reg_req.rd && !reg_req.wr && reg_req.addr == `PMS_MIC_CTRL0 |=> reg_rdata == mic_ctrl_r[0];
	endproperty
	a_rd: assert property (p_rd) else $error("read of first control register wrong"); // [RULE3]
	property p_pair_order;
		mic_valid[2] |-> mic_valid[3] && $past(mic_ctrl_r[1].en, 4);
	endproperty
	a_pair_order: assert property (p_pair_order) else $error("channel 2 without second register"); // [RULE4]
	property p_max_four;
		mic_valid[0] |-> mic_valid[1] && mic_ctrl_r[0].pin < 5'(NPINS);
	endproperty
	a_max_four: assert property (p_max_four) else $error("channel pair broken"); // [RULE1]
	property p_fault;
		cfg_r[5].mode == PMS_FAULT ##1 cfg_r[5].mode == PMS_FAULT |-> pin_out[5] == $past(fault_r) && pin_oe[5];
	endproperty
	a_fault: assert property (p_fault) else $error("fault flag not on pin"); // [RULE9]
	// register writes and the general-purpose state taken at the tick
	property p_ctrl0_wr;
		reg_req.wr && reg_req.addr == `PMS_MIC_CTRL0 |=> mic_ctrl_r[0] == $past(reg_req.wdata);
	endproperty
	a_ctrl0_wr: assert property (p_ctrl0_wr) else $error("first control register not written"); // [RULE3]
	property p_mode_wr;
		reg_req.wr && reg_req.addr == `PMS_MODE_LO |=> cfg_r[0] == $past(reg_req.wdata[3:0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("first pin mode not written"); // [RULE9]
	property p_gout_mask;
		fs_tick |=> (gout_r & ~$past(out_mask)) == '0;
	endproperty
	a_gout_mask: assert property (p_gout_mask) else $error("program value kept for a non-output pin"); // [RULE12]
	property p_sw_in;
		fs_tick && cfg_r[5].mode == PMS_SW_IN |=> gin_r[5] == $past(sw_r[5]);
	endproperty
	a_sw_in: assert property (p_sw_in) else $error("software input not taken at the tick"); // [RULE9]
	property p_hw_in;
		fs_tick && cfg_r[10].mode == PMS_HW_IN |=> gin_r[10] == $past(deb_q[10]);
	endproperty
	a_hw_in: assert property (p_hw_in) else $error("hardware input not taken at the tick"); // [RULE10] [RULE11]
	// scenario covers
	c_mic0: cover property (mic_valid[0]);
	c_mic2: cover property (mic_valid[2]);
	c_tick_out: cover property (fs_tick ##1 (pin_oe != '0));
	c_deb: cover property (cfg_r[10].deb && $rose(deb_q[10]));
endmodule

/* File: rtl/pms_regs.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 16-bit register addresses on the slave control port
// Notes: included by bare name
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH
`define PMS_MIC_CTRL0     16'hf560
`define PMS_MIC_CTRL1     16'hf561
`define PMS_MODE_LO       16'hf510
`define PMS_MODE_HI       16'hf5c0
`define PMS_WR_LO         16'hf520
`define PMS_WR_HI         16'hf5d0
`define PMS_RD_LO         16'hf530
`define PMS_RD_HI         16'hf5e0
`define PMS_LO_PINS       16'd14
`define PMS_HI_PINS       16'd11
`define PMS_MIC_PIN_LSB   0
`define PMS_MIC_EN_BIT    5
`define PMS_MODE_DEB_BIT  3
`define PMS_MIC_CTRL_RST  16'h0000
`define PMS_MODE_RST      4'h0
`define PMS_CLK_NS        10
`define PMS_DEB_NS        10000
`define PMS_DEB_CYC       (`PMS_DEB_NS / `PMS_CLK_NS)
`define PMS_DECIM         64
`endif

/* File: rtl/pms_pkg.sv */
// Purpose: shared types of the microphone input and shared pin block
// Assumes: nothing
// Notes: constants live in pms_regs.svh
package pms_pkg;
	typedef enum logic [2:0] {
		PMS_HW_IN, PMS_SW_IN, PMS_OUT_PU, PMS_OUT_NOPU, PMS_MIC, PMS_FAULT, PMS_SPI_SS
	} pms_mode_t;
	typedef struct packed {
		logic      deb;
		pms_mode_t mode;
	} pms_pin_cfg_t;
	typedef struct packed {
		logic [9:0] rsvd;
		logic       en;
		logic [4:0] pin;
	} pms_mic_ctrl_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pms_reg_req_t;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} pms_pair_t;
endpackage

/* File: rtl/pms_debounce.sv */
// Purpose: synchronise one shared pin input and optionally debounce it
// Assumes: raw pin is asynchronous to clk
// Notes: with deb_en set, the debounced value moves only after DEB_CYC stable cycles; without it, q follows the synced pin
`timescale 1ns/1ns
`include "pms_regs.svh"
module pms_debounce #(
	parameter int DEB_CYC = `PMS_DEB_CYC
) (
	input  wire logic clk,    // core clock
	input  wire logic reset,  // async reset, active high
	input  wire logic pin_raw, // raw pin level
	input  wire logic deb_en, // debounce enabled
	output logic      q       // synchronised level
);
	import pms_pkg::*;
	logic        s1_r, s2_r, q_r, q_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	assign q = q_r;
	// next value: follow the synced pin or wait for it to stay put
	always_comb begin
		q_nxt = q_r;
		cnt_nxt = 16'h0000;
		if (!deb_en) begin
			q_nxt = s2_r;
		end else if (s2_r != q_r) begin
			if (cnt_r == 16'(DEB_CYC - 1)) begin // [RULE10]
				q_nxt = s2_r;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
	end
	// two-stage synchroniser and state registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			q_r <= 1'b0;
			cnt_r <= 16'h0000;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
			q_r <= q_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	property p_deb_hold;
		@(posedge clk) disable iff (reset)
		(deb_en && $past(deb_en) && $changed(q_r)) |-> $past(cnt_r) == 16'(DEB_CYC - 1);
	endproperty
	a_deb_hold: assert property (p_deb_hold) else $error("debounced level moved early"); // [RULE10]
endmodule

/* File: rtl/pms_mic_pair.sv */
// Purpose: capture one shared microphone data line and decimate both channels
// Assumes: bclk is the master bit clock that also clocks the microphones
// Notes: words cross to clk with a toggle; a word is held DECIM bit clocks
`timescale 1ns/1ns
`include "pms_regs.svh"
module pms_mic_pair #(
	parameter int DECIM = `PMS_DECIM
) (
	input  wire logic   clk,       // core clock
	input  wire logic   reset,     // async reset, active high
	input  wire logic   bclk,      // microphone bit clock
	input  wire logic   pdm_in,    // shared data line
	input  wire logic   en,        // pair enabled, clk domain
	output pms_pkg::pms_pair_t smp, // decimated samples
	output logic        smp_valid  // one-cycle pulse per sample pair
);
	import pms_pkg::*;
	logic       en1_r, en2_r, lcap_r, rcap_n_r, rcap_r, tog_r;
	logic [6:0] lcnt_r, rcnt_r, lcnt_nxt, rcnt_nxt, bit_r, bit_nxt;
	logic [6:0] lhold_r, rhold_r;
	logic       c1_r, c2_r, c3_r, vld_r;
	pms_pair_t  smp_r, smp_nxt;
	// left on the rising edge, right on the falling edge
	always_ff @(negedge bclk or posedge reset) begin
		if (reset) rcap_n_r <= 1'b0;
		else rcap_n_r <= pdm_in; // [RULE13]
	end
	// density count over one decimation window
	always_comb begin
		bit_nxt = bit_r + 7'h01;
		lcnt_nxt = lcnt_r + {6'h00, lcap_r};
		rcnt_nxt = rcnt_r + {6'h00, rcap_r};
		if (!en2_r || bit_r == 7'(DECIM - 1)) begin // [RULE7]
			bit_nxt = 7'h00;
			lcnt_nxt = 7'h00;
			rcnt_nxt = 7'h00;
		end
	end
	// bit clock domain registers
	always_ff @(posedge bclk or posedge reset) begin
		if (reset) begin
			en1_r <= 1'b0; en2_r <= 1'b0; lcap_r <= 1'b0; rcap_r <= 1'b0;
			bit_r <= 7'h00; lcnt_r <= 7'h00; rcnt_r <= 7'h00;
			lhold_r <= 7'h00; rhold_r <= 7'h00; tog_r <= 1'b0;
		end else begin
			en1_r <= en;
			en2_r <= en1_r;
			lcap_r <= pdm_in; // [RULE13]
			rcap_r <= rcap_n_r;
			bit_r <= bit_nxt;
			lcnt_r <= lcnt_nxt;
			rcnt_r <= rcnt_nxt;
			if (en2_r && bit_r == 7'(DECIM - 1)) begin
				lhold_r <= lcnt_r + {6'h00, lcap_r};
				rhold_r <= rcnt_r + {6'h00, rcap_r};
				tog_r <= ~tog_r;
			end
		end
	end
	// map a ones count to a bipolar word
	function automatic logic [15:0] to_pcm(input logic [6:0] c);
		if (c[6]) to_pcm = 16'h7fff;
		else to_pcm = {c[5:0], 10'h000} - 16'h8000;
	endfunction
	always_comb begin
		smp_nxt = smp_r;
		if (c2_r != c3_r) begin
			smp_nxt.left = to_pcm(lhold_r);
			smp_nxt.right = to_pcm(rhold_r);
		end
	end
	// toggle crossing into the core clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			c1_r <= 1'b0; c2_r <= 1'b0; c3_r <= 1'b0; smp_r <= '0;
			vld_r <= 1'b0;
		end else begin
			c1_r <= tog_r;
			c2_r <= c1_r;
			c3_r <= c2_r;
			smp_r <= smp_nxt;
			vld_r <= c2_r ^ c3_r;
		end
	end
	assign smp = smp_r;
	assign smp_valid = vld_r; // registered beside smp so pulse and word stand together
	property p_win;
		@(posedge bclk) disable iff (reset)
		(en2_r && bit_r == 7'(DECIM - 1)) |=> $changed(tog_r) && bit_r == 7'h00;
	endproperty
	a_win: assert property (p_win) else $error("decimation window not closed"); // [RULE7]
endmodule

/* File: test/pms_mic_model.sv */
// Purpose: one pair of pdm microphones sharing a data line
// Assumes: bclk is the only clock the pair sees
// Notes: pattern 0 all zeros, 1 all ones, 2 alternating bits
`timescale 1ns/1ns
module pms_mic_model #(
	parameter int LPAT = 1,
	parameter int RPAT = 2
) (
	input  wire logic bclk, // bit clock from the master port
	output logic      dat   // shared data line
);
	logic t = 1'b0;
	initial dat = 1'b0;
	function automatic logic pat(input int p, input logic ph);
		return (p == 2) ? ph : (p == 1);
	endfunction
	// left mic drives after the fall, sampled at the rise
	always @(negedge bclk) begin
		t = ~t;
		dat <= pat(LPAT, t);
	end
	// right mic drives after the rise, sampled at the fall
	always @(posedge bclk) begin
		dat <= pat(RPAT, t);
	end
endmodule

/* File: test/pms_top_tb_top.sv */
// Purpose: self-checking bench of the mic and shared pin block
// Assumes: short debounce count, full 64-bit decimation window
// Notes: reads and mic samples are compared by a monitor process
`timescale 1ns/1ns
module pms_top_tb_top;
	import pms_pkg::*;
	logic          clk = 1'b0;
	logic          reset = 1'b1;
	logic          bclk_free = 1'b0;
	logic          bclk_gate = 1'b1;
	wire logic     mic_bclk;
	pms_reg_req_t  req = '0;
	logic [15:0]   reg_rdata;
	logic          fs_tick = 1'b0;
	logic [24:0]   pin_drv = '0;
	wire  [24:0]   pin_in;
	logic [24:0]   pin_out, pin_oe, pin_pu, gp_to_core, gp_in_valid;
	logic [24:0]   gp_from_core = '0;
	logic          fault_flag = 1'b0;
	logic          spi_ss = 1'b0;
	pms_pair_t     mic_pair0, mic_pair1;
	logic [3:0]    mic_valid;
	logic          mic_clk_req, d0, d1, rd_seen;
	logic [15:0]   rq[$];
	int            num_errors = 0;
	int            tests_run = 0;
	int            mcnt = 0;
	int            tmo = 0;
	int            k;
	logic [31:0]   v;
	logic          eo;
	// clocks: core 10 ns, bit clock 6 ns gated by the clock request
	always #5 clk = ~clk;
	initial #1 forever #3 bclk_free = ~bclk_free; // two-channel serial port bit clock
	// gate moves only while the bit clock is low, so no runt edges reach the pairs
	always @(negedge bclk_free) bclk_gate <= mic_clk_req | reset;
	assign mic_bclk = bclk_free & bclk_gate;
	assign pin_in = {pin_drv[24:8], d1, pin_drv[6:4], d0, pin_drv[2:0]};
	pms_mic_model #(.LPAT(1), .RPAT(2)) mic0 (.bclk(mic_bclk), .dat(d0));
	pms_mic_model #(.LPAT(0), .RPAT(1)) mic1 (.bclk(mic_bclk), .dat(d1));
	pms_top #(.DEB_CYC(4)) DUT (
		.clk(clk), .reset(reset), .mic_bclk(mic_bclk), .reg_req(req),
		.reg_rdata(reg_rdata), .fs_tick(fs_tick), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
		.gp_from_core(gp_from_core), .gp_to_core(gp_to_core),
		.gp_in_valid(gp_in_valid), .fault_flag(fault_flag), .spi_ss(spi_ss),
		.mic_pair0(mic_pair0), .mic_pair1(mic_pair1),
		.mic_valid(mic_valid), .mic_clk_req(mic_clk_req));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic go();
		@(posedge clk);
		#1;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		go();
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		go();
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		go();
		req.rd = 1'b1;
		req.addr = a;
		rq.push_back(e);
		go();
		req.rd = 1'b0;
	endtask
	task automatic tick();
		go();
		fs_tick = 1'b1;
		go();
		fs_tick = 1'b0;
	endtask
	// monitor: read data one cycle after the strobe, mic words with each pulse
	always @(posedge clk) begin
		if (rd_seen === 1'b1)
			chk("reg_rdata", reg_rdata, rq.pop_front());
		rd_seen <= req.rd;
		if (mic_valid !== 4'h0) begin
			mcnt++;
			chk("pair valid", {mic_valid[1], mic_valid[3]}, {mic_valid[0], mic_valid[2]});
		end
		if (mic_valid[0] === 1'b1)
			chk("mic_pair0", mic_pair0, 32'h7fff0000);
		if (mic_valid[2] === 1'b1)
			chk("mic_pair1", mic_pair1, 32'h80007fff);
		tmo++;
		if (tmo == 20000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		void'($urandom(32'had5ea42a));
		cyc(2);
		reset = 1'b0;
		rd(16'hf560, 16'h0000);
		rd(16'hf5ff, 16'h0000);
		// every mode on pin 5, fault and select lines random
		gp_from_core[5] = 1'b1;
		for (k = 0; k < 7; k++) begin
			v = $urandom;
			fault_flag = v[0];
			spi_ss = v[1];
			wr(16'hf515, 16'(k));
			wr(16'hf525, 16'h0001);
			tick();
			cyc(4);
			eo = (k == 2 || k == 3 || k == 5 || k == 6);
			chk("oe5", pin_oe[5], eo);
			chk("out5", pin_out[5], (k == 5) ? v[0] : (k == 6) ? v[1] : (k == 2 || k == 3));
			chk("pu5", pin_pu[5], k == 2);
			chk("inv5", gp_in_valid[5], k < 2);
			chk("gin5", gp_to_core[5], k == 1);
		end
		// last pin and pin 13 are reachable
		wr(16'hf5ca, 16'h0003);
		wr(16'hf51d, 16'h0002);
		rd(16'hf5ca, 16'h0003);
		tick();
		cyc(4);
		chk("oe24", {pin_oe[24], pin_oe[13], pin_pu[13]}, 3'h7);
		// output refreshed only at a sample tick
		wr(16'hf510, 16'h0003);
		v = $urandom;
		gp_from_core = v[24:0];
		tick();
		cyc(3);
		chk("out0", pin_out[0], v[0]);
		gp_from_core = ~v[24:0];
		cyc(6);
		chk("out0 hold", pin_out[0], v[0]);
		// debounced hardware input on pin 10
		wr(16'hf51a, 16'h0008);
		pin_drv[10] = 1'b1;
		cyc(2);
		pin_drv[10] = 1'b0;
		cyc(10);
		tick();
		cyc(3);
		chk("glitch", gp_to_core[10], 1'b0);
		pin_drv[10] = 1'b1;
		cyc(12);
		tick();
		cyc(3);
		chk("deb high", gp_to_core[10], 1'b1);
		rd(16'hf53a, 16'h0001);
		pin_drv[10] = 1'b0;
		cyc(12);
		chk("gin hold", gp_to_core[10], 1'b1);
		// two mic pairs on pins 3 and 7
		wr(16'hf513, 16'h0004);
		wr(16'hf517, 16'h0004);
		wr(16'hf560, 16'h0023);
		wr(16'hf561, 16'h0027);
		rd(16'hf561, 16'h0027);
		chk("clk req", mic_clk_req, 1'b1);
		cyc(200);
		chk("mic pulses", mcnt > 2, 1'b1);
		wr(16'hf560, 16'h0000);
		wr(16'hf561, 16'h0000);
		cyc(20);
		k = mcnt;
		cyc(100);
		chk("mic off", mcnt, k);
		chk("clk off", mic_clk_req, 1'b0);
		results();
	end
endmodule
